/* shared/hssp_pkg.sv */
package hssp_pkg;
  // Interface modes
  typedef enum logic {HSSP_MODE_SERIAL, HSSP_MODE_USB} hssp_mode_t;

  // Power states of the engine
  typedef enum logic [1:0] {HSSP_PWR_ON, HSSP_PWR_OFF, HSSP_PWR_WAKE} hssp_pwr_t;

  localparam int FIFO_DEPTH = 4;
  localparam int DATA_WIDTH = 8;
  localparam int PWM_WIDTH = 8;

  // Reset values
  localparam logic RST_POL_SW = 1'b0;
  localparam logic RST_SER_IDLE = 1'b1;
  localparam logic RST_OD_OE_N = 1'b1;
  localparam logic RST_SYNC = 1'b1;

  // Beeper modes
  localparam logic [1:0] BEEP_OFF = 2'h0;
  localparam logic [1:0] BEEP_DC = 2'h1;
  localparam logic [1:0] BEEP_PWM = 2'h2;

  // Status request from the engine core
  typedef struct packed {
    logic power_off;
    logic good_read;
    logic [1:0] beep_mode;
    logic [PWM_WIDTH-1:0] beep_duty;
  } hssp_status_t;

  // Pins after synchronisation
  typedef struct packed {
    logic rx;
    logic cts;
    logic pol;
    logic wake_n;
    logic trig_n;
  } hssp_pins_t;
endpackage

/* core/hssp_fifo.sv */
`timescale 1ns/1ns
module hssp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // hssp_fifo

/* core/hssp_top.sv */
`timescale 1ns/1ns
// Summary of operation
// [RL1] Pin functions follow selected serial or USB mode
// [RL2] External low polarity select forces inverted polarity
// [RL3] Software may drive polarity select pin low
// [RL4] Receive and transmit lines follow polarity setting
// [RL5] CTS input, RTS output follow polarity setting
// [RL6] Power-off indicator high only in power off
// [RL7] Beeper idle high; steady low or PWM
// [RL8] Good-read output pulled low on good read
// [RL9] Low wake input wakes device from power off
// [RL10] Low trigger line starts a read
// [RL11] Host only floats or grounds trigger line
// [RL12] Aim function unsupported; wake only
// [RL13] Default polarity is normal, non-inverted
// [RL14] Wake low at power down refuses stop
// [RL15] Trigger, wake, polarity inputs double synchronised
module hssp_top #(
  parameter int WIDTH = hssp_pkg::DATA_WIDTH,
  parameter int DEPTH = hssp_pkg::FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire hssp_pkg::hssp_mode_t mode,
  input wire logic sw_invert,
  input wire logic sw_drive_pol_low,
  input wire hssp_pkg::hssp_status_t status,
  input wire logic power_down_req,
  input wire logic [WIDTH-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  input wire logic tx_line,
  output logic rx_line,
  input wire logic rts_core,
  output logic cts_core,
  input wire logic serial_polarity_select_in,
  output logic serial_polarity_select_out,
  output logic serial_polarity_select_oe_n,
  input wire logic rxd_pin,
  output logic txd_pin,
  input wire logic cts_pin,
  output logic rts_pin,
  output logic power_off_indicator_oe_n,
  output logic beeper_drive_low_oe_n,
  output logic good_read_led_low_oe_n,
  input wire logic wake_request_low,
  input wire logic read_trigger_low_in,
  output logic read_trigger_low_out,
  output logic read_trigger_low_oe_n,
  output logic polarity_inverted,
  output logic trigger_active,
  output logic wake_event,
  output logic stop_refused,
  output logic in_power_off,
  output logic [WIDTH-1:0] fifo_data,
  output logic fifo_valid,
  input wire logic fifo_ready
);
  hssp_pkg::hssp_pins_t meta;
  hssp_pkg::hssp_pins_t sync;
  hssp_pkg::hssp_pwr_t pwr;
  hssp_pkg::hssp_pwr_t next_pwr;
  logic [hssp_pkg::PWM_WIDTH-1:0] pwm_cnt;
  logic [WIDTH-1:0] q_data;
  logic q_valid;

  // Two-stage synchronisers; first stage feeds only the second
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '{default: hssp_pkg::RST_SYNC};
      sync <= '{default: hssp_pkg::RST_SYNC};
    end else begin
      meta <= '{rxd_pin, cts_pin, serial_polarity_select_in, wake_request_low,
                read_trigger_low_in}; // RL15
      sync <= meta; // RL15
    end
  end

  wire serial_mode = (mode == hssp_pkg::HSSP_MODE_SERIAL); // RL1
  // Pin low from host or from our own drive inverts; USB ignores the pin
  wire inv = serial_mode && (sw_invert || !sync.pol); // RL2 RL13 RL1
  wire wake_low = !sync.wake_n; // RL9 RL12
  wire trig_low = !sync.trig_n; // RL10 RL11
  wire beep_low = (status.beep_mode == hssp_pkg::BEEP_DC) ||
                  ((status.beep_mode == hssp_pkg::BEEP_PWM) &&
                   (pwm_cnt < status.beep_duty)); // RL7

  always_comb begin
    next_pwr = pwr;
    case (pwr)
      hssp_pkg::HSSP_PWR_ON: begin
        // Stop only with wake idle high and serial mode
        if (power_down_req && !wake_low && !trig_low && serial_mode) begin
          next_pwr = hssp_pkg::HSSP_PWR_OFF; // RL14
        end
      end
      hssp_pkg::HSSP_PWR_OFF: begin
        if (wake_low || trig_low) begin
          next_pwr = hssp_pkg::HSSP_PWR_WAKE; // RL9
        end
      end
      hssp_pkg::HSSP_PWR_WAKE: next_pwr = hssp_pkg::HSSP_PWR_ON;
      default: next_pwr = hssp_pkg::HSSP_PWR_ON;
    endcase
  end

  // Power state; the wake step gives the core one cycle to restart
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwr <= hssp_pkg::HSSP_PWR_ON;
    end else begin
      pwr <= next_pwr;
    end
  end

  // Free-running PWM phase; the beeper period is one full wrap
  always_ff @(posedge mclk) begin
    if (rst) begin
      pwm_cnt <= '0;
    end else begin
      pwm_cnt <= pwm_cnt + 1'b1;
    end
  end

  // Transmit data buffered for the core; the queue head goes out on fifo_data, not the transmit line
  hssp_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(q_valid),
    .out_ready(fifo_ready),
    .out_data(q_data)
  );

  // Polarity applied in one place for all four lines; USB parks them idle
  function automatic logic line_level(input logic ser, input logic bit_in, input logic flip);
    return ser ? (bit_in ^ flip) : hssp_pkg::RST_SER_IDLE;
  endfunction

  function automatic logic is_off(input hssp_pkg::hssp_pwr_t state);
    return state == hssp_pkg::HSSP_PWR_OFF;
  endfunction

  // In USB mode these pins belong to the transceiver
  wire next_txd = line_level(serial_mode, tx_line, inv); // RL4 RL1
  wire next_rts = line_level(serial_mode, rts_core, inv); // RL5 RL1
  wire next_rx = line_level(serial_mode, sync.rx, inv); // RL4 RL1
  wire next_cts = line_level(serial_mode, sync.cts, inv); // RL5 RL1
  // Our own pull on the select pin only makes sense in serial mode
  wire next_pol_oe_n = !(sw_drive_pol_low && serial_mode); // RL3
  // Released only in power off, so the on-engine pull-up shows it high
  wire next_pwr_oe_n = is_off(next_pwr); // RL6
  wire next_wake_event = is_off(pwr) && wake_low; // RL9
  // A wake low while already on is not an event; only the refusal is reported
  wire next_stop_refused = (pwr == hssp_pkg::HSSP_PWR_ON) && power_down_req &&
                           wake_low; // RL14

  // Serial lines; reset parks them at the idle level
  always_ff @(posedge mclk) begin
    if (rst) begin
      txd_pin <= hssp_pkg::RST_SER_IDLE;
      rts_pin <= hssp_pkg::RST_SER_IDLE;
      rx_line <= hssp_pkg::RST_SER_IDLE;
      cts_core <= hssp_pkg::RST_SER_IDLE;
    end else begin
      txd_pin <= next_txd; // RL4
      rts_pin <= next_rts; // RL5
      rx_line <= next_rx; // RL4
      cts_core <= next_cts; // RL5
    end
  end

  // Open-drain pins: a low enable pulls the pin down, high lets it float up
  always_ff @(posedge mclk) begin
    if (rst) begin
      serial_polarity_select_out <= 1'b0;
      serial_polarity_select_oe_n <= hssp_pkg::RST_OD_OE_N;
      power_off_indicator_oe_n <= 1'b0;
      beeper_drive_low_oe_n <= hssp_pkg::RST_OD_OE_N;
      good_read_led_low_oe_n <= hssp_pkg::RST_OD_OE_N;
      read_trigger_low_out <= 1'b0;
      read_trigger_low_oe_n <= hssp_pkg::RST_OD_OE_N;
    end else begin
      serial_polarity_select_out <= 1'b0; // RL3
      serial_polarity_select_oe_n <= next_pol_oe_n; // RL3
      power_off_indicator_oe_n <= next_pwr_oe_n; // RL6
      beeper_drive_low_oe_n <= !beep_low; // RL7
      good_read_led_low_oe_n <= !status.good_read; // RL8
      // The trigger line is only listened to; the host owns the low level
      read_trigger_low_out <= 1'b0; // RL10
      read_trigger_low_oe_n <= hssp_pkg::RST_OD_OE_N; // RL10
    end
  end

  // Status levels for the engine core
  always_ff @(posedge mclk) begin
    if (rst) begin
      polarity_inverted <= hssp_pkg::RST_POL_SW;
      trigger_active <= 1'b0;
      wake_event <= 1'b0;
      stop_refused <= 1'b0;
      in_power_off <= 1'b0;
    end else begin
      polarity_inverted <= inv; // RL2
      trigger_active <= trig_low; // RL10
      wake_event <= next_wake_event; // RL9
      stop_refused <= next_stop_refused; // RL14
      in_power_off <= is_off(next_pwr); // RL6
    end
  end

  // Registered copy of the queue head; it trails the queue by one cycle
  always_ff @(posedge mclk) begin
    if (rst) begin
      fifo_data <= '0;
      fifo_valid <= 1'b0;
    end else begin
      fifo_data <= q_data;
      fifo_valid <= q_valid;
    end
  end
endmodule // hssp_top

/* test/hssp_top_properties.sv */
`timescale 1ns/1ns
module hssp_top_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire hssp_pkg::hssp_mode_t mode,
  input wire logic sw_invert,
  input wire logic sw_drive_pol_low,
  input wire hssp_pkg::hssp_status_t status,
  input wire logic tx_line,
  input wire logic serial_polarity_select_in,
  input wire logic serial_polarity_select_oe_n,
  input wire logic txd_pin,
  input wire logic power_off_indicator_oe_n,
  input wire logic beeper_drive_low_oe_n,
  input wire logic good_read_led_low_oe_n,
  input wire logic read_trigger_low_in,
  input wire logic polarity_inverted,
  input wire logic trigger_active,
  input wire logic in_power_off
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire ser = (mode == hssp_pkg::HSSP_MODE_SERIAL);
  property p_usb; (!ser)[*3] |-> !polarity_inverted; endproperty
  a_usb: assert property (p_usb) else $error("usb mode inverted");
  property p_ext; (ser && !serial_polarity_select_in)[*4] |-> polarity_inverted; endproperty
  a_ext: assert property (p_ext) else $error("select low ignored");
  property p_drv; (ser && sw_drive_pol_low)[*2] |-> !serial_polarity_select_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("select not driven");
  property p_txd;
    (ser && serial_polarity_select_in && $stable(sw_invert))[*4]
      |=> txd_pin == ($past(tx_line) ^ $past(sw_invert));
  endproperty
  a_txd: assert property (p_txd) else $error("txd polarity");
  property p_pwr; $stable(in_power_off) |-> power_off_indicator_oe_n == in_power_off; endproperty
  a_pwr: assert property (p_pwr) else $error("power off indicator");
  property p_beep; (status.beep_mode == hssp_pkg::BEEP_OFF)[*2] |-> beeper_drive_low_oe_n; endproperty
  a_beep: assert property (p_beep) else $error("beeper not idle");
  property p_good; (status.good_read)[*2] |-> !good_read_led_low_oe_n; endproperty
  a_good: assert property (p_good) else $error("good read off");
  property p_trig; (!read_trigger_low_in)[*4] |-> trigger_active; endproperty
  a_trig: assert property (p_trig) else $error("trigger missed");
  c_off: cover property (in_power_off);
  c_trig: cover property (trigger_active);
  c_inv: cover property (polarity_inverted);
endmodule // hssp_top_properties
bind hssp_top hssp_top_properties i_hssp_top_properties (.*);

/* test/hssp_host_model.sv */
`timescale 1ns/1ns
module hssp_host_model (
  input wire logic gnd_pol,
  input wire logic gnd_trig,
  input wire logic wake_low,
  input wire logic serial_polarity_select_oe_n,
  input wire logic read_trigger_low_oe_n,
  output logic serial_polarity_select_in,
  output logic read_trigger_low_in,
  output logic wake_request_low
);
  // Pull-ups: a released line reads high, the host can only ground it
  assign serial_polarity_select_in = !(gnd_pol || !serial_polarity_select_oe_n);
  assign read_trigger_low_in = !(gnd_trig || !read_trigger_low_oe_n);
  assign wake_request_low = !wake_low;
endmodule // hssp_host_model

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic mclk, rst, sw_invert, sw_drive_pol_low, power_down_req, tx_valid, tx_line, rts_core;
  logic rxd_pin, cts_pin, fifo_ready, gnd_pol, gnd_trig, wake_low, tx_ready, rx_line, cts_core;
  logic serial_polarity_select_in, serial_polarity_select_out, serial_polarity_select_oe_n;
  logic txd_pin, rts_pin, power_off_indicator_oe_n, beeper_drive_low_oe_n, good_read_led_low_oe_n;
  logic wake_request_low, read_trigger_low_in, read_trigger_low_out, read_trigger_low_oe_n;
  logic polarity_inverted, trigger_active, wake_event, stop_refused, in_power_off, fifo_valid;
  logic [7:0] tx_data, fifo_data;
  hssp_pkg::hssp_mode_t mode;
  hssp_pkg::hssp_status_t status;
  int mismatches, n_compared;
  hssp_top i_hssp_top (.*);
  hssp_host_model i_hssp_host_model (.*);
  initial begin
    mclk = 0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wrap_up;
    $display("mismatches=%0d n_compared=%0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic t_pol;
    logic inv;
    for (int i = 0; i < 8; i++) begin
      inv = |i[2:0];
      @(posedge mclk);
      {sw_drive_pol_low, gnd_pol, sw_invert} <= i[2:0];
      {tx_line, rts_core, rxd_pin, cts_pin} <= {i[0], i[1], i[2], i[0]};
      cyc(6);
      chk(polarity_inverted, inv);
      chk(txd_pin, i[0] ^ inv);
      chk(rx_line, i[2] ^ inv);
      chk(rts_pin, i[1] ^ inv);
      chk(cts_core, i[0] ^ inv);
      chk({serial_polarity_select_oe_n, serial_polarity_select_out}, {!i[2], 1'b0});
    end
    @(posedge mclk);
    mode <= hssp_pkg::HSSP_MODE_USB;
    cyc(5);
    chk(polarity_inverted, 0);
    chk({txd_pin, rts_pin, rx_line, cts_core}, 4'hf);
    chk(serial_polarity_select_oe_n, 1);
    @(posedge mclk);
    mode <= hssp_pkg::HSSP_MODE_SERIAL;
    {sw_drive_pol_low, gnd_pol, sw_invert} <= 3'h0;
  endtask
  task automatic t_status;
    int n;
    @(posedge mclk);
    status <= {1'b0, 1'b1, hssp_pkg::BEEP_DC, 8'h40};
    cyc(3);
    chk(beeper_drive_low_oe_n, 0);
    chk(good_read_led_low_oe_n, 0);
    @(posedge mclk);
    status <= {1'b0, 1'b0, hssp_pkg::BEEP_PWM, 8'h40};
    cyc(4);
    n = 0;
    repeat (256) begin
      cyc(1);
      n += !beeper_drive_low_oe_n;
    end
    chk(8'(n), 8'h40);
    status <= '0;
    cyc(3);
    chk({beeper_drive_low_oe_n, good_read_led_low_oe_n}, 3);
  endtask
  task automatic t_power;
    @(posedge mclk);
    wake_low <= 1;
    cyc(3);
    @(posedge mclk);
    power_down_req <= 1;
    cyc(5);
    chk({stop_refused, in_power_off, power_off_indicator_oe_n}, 3'h4);
    @(posedge mclk);
    wake_low <= 0;
    cyc(5);
    chk({in_power_off, power_off_indicator_oe_n, stop_refused}, 3'h6);
    @(posedge mclk);
    {wake_low, power_down_req} <= 2'h2;
    cyc(3);
    chk({wake_event, in_power_off}, 2'h2);
    cyc(4);
    chk({wake_event, in_power_off, power_off_indicator_oe_n}, 3'h0);
    @(posedge mclk);
    {wake_low, gnd_trig} <= 2'h1;
    cyc(5);
    chk({trigger_active, read_trigger_low_oe_n, read_trigger_low_out}, 3'h6);
    gnd_trig <= 0;
  endtask
  task automatic t_fifo;
    @(posedge mclk);
    tx_valid <= 1;
    for (int i = 0; i < 6; i++) begin
      tx_data <= 8'h10 + 8'(i);
      @(posedge mclk);
    end
    tx_valid <= 0;
    cyc(1);
    chk(tx_ready, 0);
    for (int j = 0; j < 4; j++) begin
      cyc(2);
      chk({fifo_valid, fifo_data}, {1'b1, 8'h10 + 8'(j)});
      @(posedge mclk);
      fifo_ready <= 1;
      @(posedge mclk);
      fifo_ready <= 0;
    end
    cyc(3);
    chk({fifo_valid, tx_ready}, 1);
  endtask
  initial begin
    {rst, tx_line, rxd_pin, cts_pin, rts_core} = 5'h1f;
    {sw_invert, sw_drive_pol_low, power_down_req, tx_valid, fifo_ready} = 5'h0;
    {gnd_pol, gnd_trig, wake_low, tx_data} = 11'h0;
    mode = hssp_pkg::HSSP_MODE_SERIAL;
    status = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (5) @(posedge mclk);
    rst <= 0;
    cyc(1);
    chk({polarity_inverted, power_off_indicator_oe_n}, 0);
    chk({txd_pin, rts_pin, rx_line, cts_core}, 4'hf);
    t_pol();
    t_status();
    t_power();
    t_fifo();
    wrap_up();
  end
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule // testbench
